// ---- core/alsr_pkg.sv ----
// Shared constants and types for the ambient light readout block
`default_nettype none
package alsr_pkg;

  // ****************************************************************
  // Bus address and register map
  // ****************************************************************
  localparam logic [6:0] ALSR_SLAVE_ADDR = 7'h29;      // Fixed 7-bit slave address
  localparam logic [7:0] ALSR_REG_MODE = 8'h80;        // mode_control
  localparam logic [7:0] ALSR_REG_LOW = 8'h8C;         // light_count_low
  localparam logic [7:0] ALSR_REG_HIGH = 8'h8D;        // light_count_high
  localparam logic [7:0] ALSR_MODE_ACTIVE = 8'h03;     // Value that starts measuring
  localparam logic [7:0] ALSR_MODE_STANDBY = 8'h00;    // Value that stops measuring
  localparam logic [7:0] ALSR_MODE_RESET = 8'h00;      // Mode value after power-up
  localparam logic [7:0] ALSR_READ_NONE = 8'h00;       // Returned for blocked or unmapped reads
  localparam logic [7:0] ALSR_PTR_RESET = 8'h80;       // Pointer after power-up
  localparam logic [3:0] ALSR_BITS_PER_BYTE = 4'h8;    // Data bits before an acknowledge slot

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ALSR_CLK_HZ = 100_000_000;            // clk_sys rate
  localparam int ALSR_CLK_PERIOD_NS = 10;
  localparam int ALSR_SPIKE_NS = 10;                   // Longest spike to be rejected
  localparam int ALSR_SPIKE_CYCLES = (ALSR_SPIKE_NS + ALSR_CLK_PERIOD_NS - 1) / ALSR_CLK_PERIOD_NS;
  localparam int ALSR_SINGLE_TIME_US = 1000;           // Delay to first single result
  localparam int ALSR_SAMPLE_TIME_US = 5800;           // Spacing of ramp-up samples
  localparam int ALSR_MEAS_PER_S = 2;                  // Steady refresh rate
  localparam int ALSR_FIRST_CYCLES = ALSR_SINGLE_TIME_US * (ALSR_CLK_HZ / 1_000_000);
  localparam int ALSR_SAMPLE_CYCLES = ALSR_SAMPLE_TIME_US * (ALSR_CLK_HZ / 1_000_000);
  localparam int ALSR_REFRESH_CYCLES = ALSR_CLK_HZ / ALSR_MEAS_PER_S;

  // ****************************************************************
  // Averaging
  // ****************************************************************
  localparam logic [5:0] ALSR_AVG_ONE = 6'h01;         // Single measurement
  localparam logic [5:0] ALSR_AVG_LOW = 6'h08;         // 8-fold average
  localparam logic [5:0] ALSR_AVG_MID = 6'h10;         // 16-fold average
  localparam logic [5:0] ALSR_AVG_FULL = 6'h20;        // 32-fold average
  localparam int ALSR_SH_LOW = 3;
  localparam int ALSR_SH_MID = 4;
  localparam int ALSR_SH_FULL = 5;
  localparam int ALSR_STEADY_CYCLES = ALSR_REFRESH_CYCLES / 32;
  localparam int ALSR_CNT_W = 26;                      // Holds the longest interval

  // Bus engine states
  typedef enum logic [2:0] {
    ALSR_ST_IDLE, ALSR_ST_ADDR, ALSR_ST_ADDR_ACK, ALSR_ST_WR_BYTE,
    ALSR_ST_WR_ACK, ALSR_ST_RD_BYTE, ALSR_ST_RD_ACK
  } alsr_bus_st_t;

  // Measurement phases
  typedef enum logic [1:0] {ALSR_PH_IDLE, ALSR_PH_RAMP, ALSR_PH_STEADY} alsr_phase_t;

  // Average of an accumulated sum over 2**sh samples
  function automatic logic [15:0] alsr_avg(input logic [20:0] sum, input int sh);
    logic [20:0] s;
    s = sum >> sh;
    return s[15:0];
  endfunction

endpackage
`default_nettype wire

// ---- core/alsr_meas_if.sv ----
// Link between the bus engine and the measurement sequencer
`default_nettype none
interface alsr_meas_if;
  logic enable;          // Active mode, measurements running
  logic [15:0] result;   // Latest published light count
  modport ctl (output enable, input result);
  modport unit (input enable, output result);
endinterface
`default_nettype wire

// ---- core/alsr_pin_filter.sv ----
// Three-stage synchroniser with spike rejection for one bus line
`default_nettype none
module alsr_pin_filter
  import alsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic line_in,
  output logic line_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0] sync;    // [0] first stage, [1] second, [2] third
    logic level;         // Accepted line level
  } alsr_filt_st_t;

  alsr_filt_st_t q, d;

  // Only stages two and three are compared; a spike no longer than
  // ALSR_SPIKE_CYCLES cannot make them agree on a new level
  always_comb begin
    d = q;
    d.sync = {q.sync[1:0], line_in};
    if (q.sync[1] == q.sync[2]) begin
      d.level = q.sync[2];
    end
  end

  // Idle bus lines sit high, so the reset value is high
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign line_out = q.level;

endmodule
`default_nettype wire

// ---- core/alsr_meas.sv ----
// Internally timed measurement sequencer with staged averaging
`default_nettype none
module alsr_meas
  import alsr_pkg::*;
#(
  parameter int FIRST_CYCLES = ALSR_FIRST_CYCLES,
  parameter int SAMPLE_CYCLES = ALSR_SAMPLE_CYCLES,
  parameter int STEADY_CYCLES = ALSR_STEADY_CYCLES
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [15:0] light_raw,
  alsr_meas_if.unit link
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    alsr_phase_t phase;
    logic [ALSR_CNT_W-1:0] cnt;  // Cycles left to the next sample
    logic [20:0] sum;            // Accumulated raw samples
    logic [5:0] n;               // Samples in the current sum
    logic [15:0] result;         // Published count
  } alsr_meas_st_t;

  alsr_meas_st_t q, d;
  logic [20:0] sum_n;
  logic [5:0] n_n;

  // Sampling, accumulation and publishing of results
  always_comb begin
    d = q;
    sum_n = q.sum + {5'h00, light_raw};
    n_n = q.n + ALSR_AVG_ONE;
    if (!link.enable) begin
      // Stand-by: no measurement, last result is kept
      d.phase = ALSR_PH_IDLE;
      d.sum = '0;
      d.n = '0;
    end else if (q.phase == ALSR_PH_IDLE) begin
      d.phase = ALSR_PH_RAMP;
      d.cnt = ALSR_CNT_W'(FIRST_CYCLES - 1);
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end else begin
      d.sum = sum_n;
      d.n = n_n;
      d.cnt = ALSR_CNT_W'((q.phase == ALSR_PH_RAMP ? SAMPLE_CYCLES : STEADY_CYCLES) - 1);
      if (q.phase == ALSR_PH_RAMP) begin
        // Intermediate results only after activation
        if (n_n == ALSR_AVG_ONE) begin
          d.result = light_raw;
        end else if (n_n == ALSR_AVG_LOW) begin
          d.result = alsr_avg(sum_n, ALSR_SH_LOW);
        end else if (n_n == ALSR_AVG_MID) begin
          d.result = alsr_avg(sum_n, ALSR_SH_MID);
        end
      end
      if (n_n == ALSR_AVG_FULL) begin
        // Full average, then a fresh one every half second
        d.result = alsr_avg(sum_n, ALSR_SH_FULL);
        d.phase = ALSR_PH_STEADY;
        d.sum = '0;
        d.n = '0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.result = q.result;

endmodule
`default_nettype wire

// ---- core/alsr_top.sv ----
// Ambient light readout: two-wire bus slave, mode control and results
`default_nettype none

module alsr_top
  import alsr_pkg::*;
#(
  parameter int FIRST_CYCLES = ALSR_FIRST_CYCLES,    // Delay to first result
  parameter int SAMPLE_CYCLES = ALSR_SAMPLE_CYCLES,  // Ramp-up sample spacing
  parameter int STEADY_CYCLES = ALSR_STEADY_CYCLES   // Steady sample spacing
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic supply_on,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [15:0] light_raw,
  output logic mode_active,
  output logic [15:0] light_count
);

  // ****************************************************************
  // State of the bus engine
  // ****************************************************************
  typedef struct packed {
    alsr_bus_st_t state;   // Transfer phase
    logic [3:0] bitcnt;    // Clock rises seen in the current byte
    logic [7:0] shift;     // Incoming byte
    logic [7:0] tx;        // Outgoing byte, MSB on the wire
    logic [7:0] ptr;       // Register pointer
    logic [7:0] mode;      // mode_control contents
    logic first;           // Next written byte is the pointer
    logic rw;              // Direction of the current transfer
    logic more;            // Master acknowledged the last read byte
    logic drive;           // Pull SDA low
    logic scl_p;           // Filtered SCL, one cycle old
    logic sda_p;           // Filtered SDA, one cycle old
  } alsr_top_st_t;

  alsr_top_st_t q, d;

  logic scl_f;             // Filtered SCL
  logic sda_f;             // Filtered SDA
  logic scl_rise;          // SCL went high
  logic scl_fall;          // SCL went low
  logic bus_start;         // START or repeated START
  logic bus_stop;          // STOP
  logic is_active;         // Mode holds the activation value

  alsr_meas_if meas ();

  // ****************************************************************
  // Pin conditioning
  // ****************************************************************
  // Each line passes four flip-flops; latency stays near 40 ns, well
  // inside the shortest clock-low phase at the high-speed rate
  alsr_pin_filter u_scl_filt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .line_in(scl_i),
    .line_out(scl_f)
  );

  alsr_pin_filter u_sda_filt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .line_in(sda_i),
    .line_out(sda_f)
  );

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  alsr_meas #(
    .FIRST_CYCLES(FIRST_CYCLES),
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .STEADY_CYCLES(STEADY_CYCLES)
  ) u_meas (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .light_raw(light_raw),
    .link(meas.unit)
  );

  // ****************************************************************
  // Bus events
  // ****************************************************************
  // Edges and conditions seen on the filtered lines; the engine is
  // clocked by clk_sys only, so any bus rate that leaves a few system
  // cycles per phase works without clock stretching
  always_comb begin
    scl_rise = scl_f & ~q.scl_p;
    scl_fall = ~scl_f & q.scl_p;
    bus_start = scl_f & q.scl_p & q.sda_p & ~sda_f;
    bus_stop = scl_f & q.scl_p & ~q.sda_p & sda_f;
  end

  assign is_active = (q.mode == ALSR_MODE_ACTIVE);

  // Byte returned for a read at the given pointer
  function automatic logic [7:0] reg_read(input logic [7:0] ptr, input logic [7:0] mode,
                                          input logic active, input logic [15:0] count);
    logic [7:0] v;
    v = ALSR_READ_NONE;
    if (ptr == ALSR_REG_MODE) begin
      v = mode;
    end else if (active && ptr == ALSR_REG_LOW) begin
      v = count[7:0];
    end else if (active && ptr == ALSR_REG_HIGH) begin
      v = count[15:8];
    end
    // Result registers are blocked in stand-by and read as zero
    return v;
  endfunction

  // ****************************************************************
  // Bus engine
  // ****************************************************************
  // Data is sampled on SCL rises and the SDA drive changes only on
  // SCL falls, so it never moves while SCL is high
  always_comb begin
    d = q;
    d.scl_p = scl_f;
    d.sda_p = sda_f;
    if (!supply_on) begin
      // Device off: engine idle, power-up values restored
      d.state = ALSR_ST_IDLE;
      d.drive = 1'b0;
      d.mode = ALSR_MODE_RESET;
      d.ptr = ALSR_PTR_RESET;
    end else if (bus_start) begin
      // A START aborts any transfer and begins an address byte
      d.state = ALSR_ST_ADDR;
      d.bitcnt = '0;
      d.drive = 1'b0;
    end else if (bus_stop) begin
      d.state = ALSR_ST_IDLE;
      d.drive = 1'b0;
    end else begin
      unique case (q.state)
        ALSR_ST_IDLE: begin
          // Wait for a START; all other traffic is not ours
          d.drive = 1'b0;
        end
        ALSR_ST_ADDR: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], sda_f};
            d.bitcnt = q.bitcnt + 1'b1;
          end else if (scl_fall && q.bitcnt == ALSR_BITS_PER_BYTE) begin
            if (q.shift[7:1] == ALSR_SLAVE_ADDR) begin
              d.rw = q.shift[0];
              d.first = 1'b1;
              d.drive = 1'b1;
              d.state = ALSR_ST_ADDR_ACK;
            end else begin
              // Other address: stay silent until the next START
              d.state = ALSR_ST_IDLE;
            end
          end
        end
        ALSR_ST_ADDR_ACK: begin
          if (scl_fall) begin
            d.bitcnt = '0;
            if (q.rw) begin
              // Read: first data bit goes out at once
              d.tx = reg_read(q.ptr, q.mode, is_active, meas.result);
              d.drive = ~d.tx[7];
              d.state = ALSR_ST_RD_BYTE;
            end else begin
              d.drive = 1'b0;
              d.state = ALSR_ST_WR_BYTE;
            end
          end
        end
        ALSR_ST_WR_BYTE: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], sda_f};
            d.bitcnt = q.bitcnt + 1'b1;
          end else if (scl_fall && q.bitcnt == ALSR_BITS_PER_BYTE) begin
            d.bitcnt = '0;
            if (q.first) begin
              d.ptr = q.shift;
              d.first = 1'b0;
              d.drive = 1'b1;
              d.state = ALSR_ST_WR_ACK;
            end else if (q.ptr == ALSR_REG_MODE) begin
              // Only mode_control takes data, in either mode
              d.mode = q.shift;
              d.drive = 1'b1;
              d.state = ALSR_ST_WR_ACK;
            end else begin
              // Read-only or unmapped target: not acknowledged
              d.state = ALSR_ST_IDLE;
            end
          end
        end
        ALSR_ST_WR_ACK: begin
          if (scl_fall) begin
            d.drive = 1'b0;
            d.state = ALSR_ST_WR_BYTE;
          end
        end
        ALSR_ST_RD_BYTE: begin
          if (scl_rise) begin
            d.bitcnt = q.bitcnt + 1'b1;
          end else if (scl_fall) begin
            if (q.bitcnt == ALSR_BITS_PER_BYTE) begin
              // Release SDA for the master's acknowledge
              d.drive = 1'b0;
              d.bitcnt = '0;
              d.state = ALSR_ST_RD_ACK;
            end else begin
              d.tx = {q.tx[6:0], 1'b0};
              d.drive = ~d.tx[7];
            end
          end
        end
        ALSR_ST_RD_ACK: begin
          if (scl_rise) begin
            d.more = ~sda_f;
          end else if (scl_fall) begin
            if (q.more) begin
              // Pointer does not advance: the same register again
              d.tx = reg_read(q.ptr, q.mode, is_active, meas.result);
              d.drive = ~d.tx[7];
              d.state = ALSR_ST_RD_BYTE;
            end else begin
              d.state = ALSR_ST_IDLE;
            end
          end
        end
        default: begin
          d.state = ALSR_ST_IDLE;
          d.drive = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Power-up: idle engine, stand-by mode, lines seen as high
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q.state <= ALSR_ST_IDLE;
      q.bitcnt <= '0;
      q.shift <= '0;
      q.tx <= '0;
      q.ptr <= ALSR_PTR_RESET;
      q.mode <= ALSR_MODE_RESET;
      q.first <= 1'b0;
      q.rw <= 1'b0;
      q.more <= 1'b0;
      q.drive <= 1'b0;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Open drain: the data value is always low, only the enable moves;
  // the clock line is never held, so the master sets the pace
  assign sda_o = 1'b0;
  assign sda_oe = q.drive & supply_on;
  assign scl_o = 1'b0;
  assign scl_oe = 1'b0;

  // Measurement runs while the mode holds the activation value and supply_on is high
  assign meas.enable = is_active & supply_on;
  assign mode_active = is_active;
  assign light_count = meas.result;

endmodule
`default_nettype wire

// ---- sim/alsr_assertions.sv ----
// Concurrent checks on the ports of the ambient light readout block
`default_nettype none
module alsr_assertions
  import alsr_pkg::*;
#(
  parameter int FIRST_CYCLES = ALSR_FIRST_CYCLES
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic supply_on,
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [15:0] light_raw,
  input wire logic mode_active,
  input wire logic [15:0] light_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // First result window
  // ****************************************************************
  localparam int F_LO = FIRST_CYCLES - 1;  // Earliest first result
  localparam int F_HI = FIRST_CYCLES + 4;  // Latest first result, pipeline slack
  logic [31:0] since_q;  // Cycles since activation
  logic first_q;  // First result still awaited
  logic [15:0] prev_q;  // Count one cycle back

  // Counter runs from activation until the first count change
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      since_q <= 32'h0000_0000;
      first_q <= 1'b0;
      prev_q <= 16'h0000;
    end else begin
      prev_q <= light_count;
      if (!mode_active) begin
        since_q <= 32'h0000_0000;
        first_q <= 1'b1;
      end else if (first_q) begin
        since_q <= since_q + 32'h0000_0001;
        if (light_count != prev_q) begin
          first_q <= 1'b0;
        end
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence activated_s;
    $rose(mode_active);
  endsequence
  sequence idle_twice_s;
    !mode_active ##1 !mode_active;
  endsequence

  scl_free_a: assert property (scl_oe == 1'b0)
    else $error("clock line driven by slave");
  low_only_a: assert property (sda_oe |-> sda_o == 1'b0)
    else $error("data line driven high");
  off_release_a: assert property (!supply_on |-> !sda_oe && !scl_oe)
    else $error("pins held while supply off");
  off_standby_a: assert property (!supply_on |=> !mode_active)
    else $error("mode kept while supply off");
  act_ack_a: assert property (activated_s |-> sda_oe)
    else $error("activation without acknowledge");
  standby_hold_a: assert property (idle_twice_s |-> $stable(light_count))
    else $error("count moved in stand-by");
  // A first result equal to the old count shows no change, so the late
  // check looks once, at the window's end, for the raw value instead
  first_late_a: assert property (first_q && mode_active && since_q == F_HI |-> light_count == light_raw)
    else $error("first result late");
  first_early_a: assert property (first_q && mode_active && $changed(light_count) |-> since_q >= F_LO)
    else $error("first result early");
  ack_timing_a: assert property ($changed(sda_oe) && supply_on && $past(supply_on)
    |-> !scl_i && !$past(scl_i, 3))
    else $error("data line moved outside clock low");
endmodule

bind alsr_top alsr_assertions #(.FIRST_CYCLES(FIRST_CYCLES)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .supply_on(supply_on), .scl_i(scl_i), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
  .light_raw(light_raw), .mode_active(mode_active), .light_count(light_count));
`default_nettype wire

// ---- sim/alsr_i2c_master.sv ----
// Behavioural two-wire bus master facing the readout block
`default_nettype none
module alsr_i2c_master (
  input wire logic clk_sys,
  input wire logic sda_w,
  output var logic scl_m,
  output var logic sda_m
);
  timeunit 1ns;
  timeprecision 100ps;
  int half = 15;  // Half bit period in cycles, sets the bus rate
  logic glitch = 1'b0;  // Inject a short spike in each high phase

  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  // Wait n falling edges, so every change lands off the sampling edge
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One clock pulse; data moves 2 cycles after the fall so no false start or stop
  task automatic clk_bit(inout logic b);
    tick(2);
    sda_m = b;
    tick(half - 2);
    scl_m = 1'b1;
    tick(half / 2);
    if (glitch) begin
      #3 {scl_m, sda_m} = ~{scl_m, sda_m};  // 5 ns spike straddling a rising edge
      #5 {scl_m, sda_m} = ~{scl_m, sda_m};
    end
    tick(half - half / 2);
    b = sda_w;  // Sampled at the end of the high phase
    scl_m = 1'b0;
  endtask

  task automatic start();
    sda_m = 1'b0;
    tick(half);
    scl_m = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_m = 1'b0;
    tick(half);
    scl_m = 1'b1;
    tick(half);
    sda_m = 1'b1;  // Both lines released to the pull-ups
    tick(half);
  endtask

  // Byte out (0xff to read), then the acknowledge slot with mack driven
  task automatic byte_x(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      b = d[i];
      clk_bit(b);
      q[i] = b;
    end
    b = mack;
    clk_bit(b);
    ack = !b;
  endtask
endmodule
`default_nettype wire

// ---- sim/ambient_light_i2c_readout_bench.sv ----
// Self-checking bench for the ambient light readout block
`default_nettype none
module ambient_light_i2c_readout_bench
  import alsr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FC = 20;  // Shortened first-result delay
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic supply_on = 1'b1;
  logic [15:0] light_raw = 16'h0000;
  logic scl_m, sda_m, scl_w, sda_w, scl_o, scl_oe, sda_o, sda_oe, mode_active;
  logic [15:0] light_count;
  logic [31:0] seed = 32'h0000_f80a;
  int n_mismatch = 0;
  int n_checks = 0;

  always #5 clk_sys = ~clk_sys;
  // Open drain lines with pull-ups: low wins
  assign scl_w = scl_m & ~scl_oe;
  assign sda_w = sda_m & ~sda_oe;

  alsr_top #(.FIRST_CYCLES(FC), .SAMPLE_CYCLES(10), .STEADY_CYCLES(10)) dut (.clk_sys(clk_sys),
    .reset_n(reset_n), .supply_on(supply_on), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .light_raw(light_raw), .mode_active(mode_active),
    .light_count(light_count));
  alsr_i2c_master m (.clk_sys(clk_sys), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  // Pointer byte first, then one data byte
  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d, output logic a);
    logic [7:0] q;
    m.start();
    m.byte_x({ALSR_SLAVE_ADDR, 1'b0}, 1'b1, q, a);
    chk("write address ack", 16'h0001, 16'(a));
    m.byte_x(p, 1'b1, q, a);
    m.byte_x(d, 1'b1, q, a);
    m.stop();
  endtask

  // Set pointer, then read one byte and end with not-acknowledge
  task automatic reg_rd(input logic [7:0] p, output logic [7:0] v);
    logic [7:0] q;
    logic a;
    m.start();
    m.byte_x({ALSR_SLAVE_ADDR, 1'b0}, 1'b1, q, a);
    m.byte_x(p, 1'b1, q, a);
    m.stop();
    m.start();
    m.byte_x({ALSR_SLAVE_ADDR, 1'b1}, 1'b1, q, a);
    chk("read address ack", 16'h0001, 16'(a));
    m.byte_x(8'hff, 1'b1, v, a);
    m.stop();
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog about a quarter above the expected run of some 72000 cycles
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    logic [7:0] v, lo, hi, q;
    logic [6:0] ad;
    logic a;
    logic [15:0] r2;
    int halves[4] = '{500, 125, 50, 15};
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    m.tick(4);
    // Stand-by after power-up
    reg_rd(ALSR_REG_MODE, v);
    chk("mode at power-up", 16'(ALSR_MODE_RESET), 16'(v));
    reg_rd(ALSR_REG_LOW, v);
    chk("blocked result read", 16'(ALSR_READ_NONE), 16'(v));
    reg_wr(ALSR_REG_HIGH, seed[7:0], a);
    chk("blocked write ack", 16'h0000, 16'(a));
    $display("test standby done");
    // Foreign addresses in both directions
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      ad = (seed[6:0] == ALSR_SLAVE_ADDR) ? (seed[6:0] ^ 7'h01) : seed[6:0];
      m.start();
      m.byte_x({ad, seed[7]}, 1'b1, q, a);
      m.stop();
      chk("foreign address ack", 16'h0000, 16'(a));
    end
    $display("test address done");
    // Activation under spikes, ramp and steady results
    seed = xs(seed);
    light_raw = seed[15:0] | 16'h0001;
    m.glitch = 1'b1;
    reg_wr(ALSR_REG_MODE, ALSR_MODE_ACTIVE, a);
    m.glitch = 1'b0;
    chk("spiked write ack", 16'h0001, 16'(a));
    chk("active flag", 16'h0001, 16'(mode_active));
    reg_rd(ALSR_REG_MODE, v);
    chk("mode read back", 16'(ALSR_MODE_ACTIVE), 16'(v));
    reg_rd(ALSR_REG_LOW, lo);
    reg_rd(ALSR_REG_HIGH, hi);
    chk("first count", light_raw, {hi, lo});
    seed = xs(seed);
    r2 = seed[15:0];
    light_raw = r2;
    m.tick(800);
    chk("steady count", r2, light_count);
    reg_rd(ALSR_REG_HIGH, hi);
    reg_rd(ALSR_REG_LOW, lo);
    chk("steady read", r2, {hi, lo});
    // Master acknowledge asks for the same register once more
    m.start();
    m.byte_x({ALSR_SLAVE_ADDR, 1'b1}, 1'b1, q, a);
    m.byte_x(8'hff, 1'b0, hi, a);
    m.byte_x(8'hff, 1'b1, v, a);
    m.stop();
    chk("acked re-read", {r2[7:0], r2[7:0]}, {hi, v});
    $display("test active done");
    // Back to stand-by, count frozen and blocked
    reg_wr(ALSR_REG_MODE, ALSR_MODE_STANDBY, a);
    chk("stand-by flag", 16'h0000, 16'(mode_active));
    reg_rd(ALSR_REG_LOW, v);
    chk("stand-by read", 16'(ALSR_READ_NONE), 16'(v));
    m.tick(400);
    chk("held count", r2, light_count);
    $display("test standby again done");
    // Supply loss while active
    light_raw = r2 ^ 16'h8000;
    reg_wr(ALSR_REG_MODE, ALSR_MODE_ACTIVE, a);
    m.tick(10);
    supply_on = 1'b0;
    m.tick(3);
    chk("off mode", 16'h0000, 16'(mode_active));
    chk("off data pin", 16'h0000, 16'(sda_oe));
    chk("clock pin level", 16'h0000, 16'(scl_o));
    supply_on = 1'b1;
    m.tick(4);
    $display("test supply done");
    // Every documented bus rate
    foreach (halves[i]) begin
      m.half = halves[i];
      reg_rd(ALSR_REG_MODE, v);
      chk("mode at rate", 16'(ALSR_MODE_RESET), 16'(v));
    end
    $display("test rates done");
    final_report();
  end
endmodule
`default_nettype wire
